// ==== inc/anc_defines.vh ====
/*
 * constants of the negotiation and configuration control block: register indices,
 * field positions, reset values and timing figures.
 * assumes inclusion by bare name from the core file; definitions only.
 */
`ifndef ANC_DEFINES_VH
`define ANC_DEFINES_VH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define ANC_IDX_CTRL 5'h00
`define ANC_IDX_STAT 5'h01
`define ANC_IDX_ADV 5'h04
`define ANC_IDX_LPA 5'h05
`define ANC_IDX_EXP 5'h06
`define ANC_IDX_SUM 5'h10
`define ANC_IDX_XCR 5'h19

// ----------------------------------------
// field positions
// ----------------------------------------
`define ANC_CTRL_SPEED 13
`define ANC_CTRL_NEGOTIATE_STRAP_ENABLE 12
`define ANC_CTRL_RESTART 9
`define ANC_CTRL_DUPLEX 8
`define ANC_XCR_AUTO 15
`define ANC_XCR_FORCE 14
`define ANC_LPA_RFAULT 13
`define ANC_LPA_NP 15
`define ANC_ABIL_HI 8
`define ANC_ABIL_LO 5

// ----------------------------------------
// fixed values
// ----------------------------------------
`define ANC_STAT_FIXED 16'h7849
`define ANC_SELECTOR 5'h01
`define ANC_PD_100_WORD 16'h0081
`define ANC_PD_10_WORD 16'h0021
`define ANC_XCR_RESET 16'h8000
`define ANC_CTRL_RESET 16'h1000
`define ANC_ADV_RESET 16'h01e1

// ----------------------------------------
// timing
// ----------------------------------------
`define ANC_BREAK_LINK_MS 1500
`define ANC_CLK_KHZ 100000
`define ANC_SWAP_CYCLES 1000

`endif

// ==== core/anc_autoneg_ctrl.v ====
/*
 * negotiation and link configuration control: straps, advertisement, partner
 * ability capture, priority resolution, parallel detection, break link timing
 * and cable pair crossover, with an ahb-lite register slave.
 * assumes link status and received pages arrive synchronous to hclk from the
 * receivers, and that the pulse encoder sends tx_page while flp_send is high.
 */
`timescale 1ns/10ps
`include "anc_defines.vh"

// Summary of operation
// RL1: negotiation strap low forces speed and duplex from the two select straps.
// RL2: negotiation strap high advertises ability sets chosen by the select straps.
// RL3: straps sampled at reset load advertisement bits 8 to 5.
// RL4: later basic control writes override the strap configuration at any time.
// RL5: while negotiating, advertisement register abilities are sent in pulse bursts.
// RL6: resolution priority 100 full, 100 half, 10 full, 10 half.
// RL7: negotiation off uses control speed and duplex bits; on ignores them.
// RL8: resolved speed reported in link status summary once link is up.
// RL9: basic status ability bits fixed set; four-pair ability bit clear.
// RL10: basic status shows complete, remote fault, link, preamble suppression.
// RL11: all abilities advertised by default; writes may clear any of them.
// RL12: base and next page words received are captured into partner ability.
// RL13: parallel detect loads 0081h or 0021h and leaves partner-able clear.
// RL14: expansion shows detect fault, partner and local next page, page, able.
// RL15: both receivers' link status drive parallel detection of the technology.
// RL16: parallel detect fault set when both good links are seen at once.
// RL17: writing one to control bit 9 restarts negotiation.
// RL18: loss of the negotiated link resumes negotiation.
// RL19: renegotiation halts transmit and pulses for the break link time.
// RL20: after forced start, software clears then sets bit 12 to negotiate.
// RL21: auto crossover uses negotiation and random seed; not in forced mode.
// RL22: crossover control bit 14 forces crossover regardless of other settings.
// RL23: sampled straps stay fixed until the next reset.
module anc_autoneg_ctrl #(
	parameter BREAK_CYCLES = `ANC_BREAK_LINK_MS * `ANC_CLK_KHZ,
	parameter SWAP_CYCLES = `ANC_SWAP_CYCLES
) (
	input wire hclk,
	input wire hresetn,
	input wire hclk_en,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire negotiate_strap_enable,
	input wire neg_select_hi,
	input wire neg_select_lo,
	input wire crossover_strap_enable,
	input wire link_10_good,
	input wire link_100_good,
	input wire rx_page_valid,
	input wire [15:0] rx_page,
	output wire flp_send,
	output wire [15:0] tx_page,
	output wire tx_halt,
	output wire speed_100,
	output wire full_duplex,
	output wire link_up,
	output wire mdi_crossover
);

// ----------------------------------------
// states and helpers
// ----------------------------------------
localparam ST_OFF = 2'd0;
localparam ST_BREAK = 2'd1;
localparam ST_ABIL = 2'd2;
localparam ST_DONE = 2'd3;
localparam [27:0] BREAK_LAST = BREAK_CYCLES - 1;
localparam [15:0] SWAP_LAST = SWAP_CYCLES - 1;

// common ability picked by priority; bit 2 marks a usable result
function [2:0] resolve;
	input [3:0] common;
	begin
		if (common[3]) begin
			resolve = 3'b111;
		end else if (common[2]) begin
			resolve = 3'b110;
		end else if (common[1]) begin
			resolve = 3'b101;
		end else if (common[0]) begin
			resolve = 3'b100;
		end else begin
			resolve = 3'b000;
		end
	end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [1:0] state_r;
reg [27:0] break_cnt_r;
reg [15:0] swap_cnt_r;
reg [15:0] lfsr_r;
reg strap_done_r;
reg armed_r;
reg ctrl_speed_r;
reg ctrl_an_r;
reg ctrl_duplex_r;
reg [15:0] adv_r;
reg [15:0] lpa_r;
reg [15:0] xcr_r;
reg pd_fault_r;
reg page_rcvd_r;
reg lp_able_r;
reg res_100_r;
reg res_fd_r;
reg op_100_r;
reg op_fd_r;
reg link_r;
reg xover_r;
reg mdi_r;
reg wr_pend_r;
reg [4:0] wr_idx_r;
reg [31:0] hrdata_r;

wire an_on;
wire addr_ok;
wire rd_take;
wire wr_take;
wire [4:0] a_idx;
wire [15:0] wd;
wire wr_ctrl;
wire restart_req;
wire [2:0] res;
wire exp_read;
wire pd_one;
wire sel_link;
reg [15:0] rd_val;
reg [3:0] strap_adv;

assign an_on = ctrl_an_r & armed_r; // [RL20]
assign addr_ok = hsel & hready & htrans[1] & hclk_en;
assign rd_take = addr_ok & ~hwrite;
assign wr_take = addr_ok & hwrite;
assign a_idx = haddr[6:2];
assign wd = hwdata[15:0];
assign wr_ctrl = wr_pend_r & hclk_en & (wr_idx_r == `ANC_IDX_CTRL);
assign restart_req = wr_ctrl & wd[`ANC_CTRL_RESTART] & an_on; // [RL17]
assign res = resolve(adv_r[`ANC_ABIL_HI:`ANC_ABIL_LO] & lpa_r[`ANC_ABIL_HI:`ANC_ABIL_LO]); // [RL6]
assign exp_read = rd_take & (a_idx == `ANC_IDX_EXP);
assign pd_one = link_10_good ^ link_100_good; // [RL15]
assign sel_link = (an_on ? res_100_r : ctrl_speed_r) ? link_100_good : link_10_good;

// ----------------------------------------
// ahb-lite slave
// ----------------------------------------
// a read right behind a write waits one cycle so it sees the new value
assign hreadyout = hclk_en & ~(wr_pend_r & hsel & htrans[1] & ~hwrite);
assign hresp = 1'b0;
assign hrdata = hrdata_r;

always @* begin
	rd_val = 16'h0000;
	case (a_idx)
		`ANC_IDX_CTRL: begin
			rd_val = {2'b00, ctrl_speed_r, ctrl_an_r, 3'b000, ctrl_duplex_r, 8'h00};
		end
		`ANC_IDX_STAT: begin
			rd_val = `ANC_STAT_FIXED; // [RL9]
			rd_val[5] = (state_r == ST_DONE); // [RL10]
			rd_val[4] = lpa_r[`ANC_LPA_RFAULT];
			rd_val[2] = link_r;
		end
		`ANC_IDX_ADV: begin
			rd_val = adv_r;
		end
		`ANC_IDX_LPA: begin
			rd_val = lpa_r;
		end
		`ANC_IDX_EXP: begin
			rd_val = {11'h000, pd_fault_r, lpa_r[`ANC_LPA_NP], 1'b0, page_rcvd_r, lp_able_r}; // [RL14]
		end
		`ANC_IDX_SUM: begin
			rd_val = {11'h000, (state_r == ST_DONE), 1'b0, op_fd_r, ~op_100_r & link_r, link_r}; // [RL8]
		end
		`ANC_IDX_XCR: begin
			rd_val = xcr_r;
		end
		default: begin
			rd_val = 16'h0000;
		end
	endcase
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_r <= 1'b0;
		wr_idx_r <= 5'h00;
		hrdata_r <= 32'h0000_0000;
	end else if (hclk_en) begin
		if (wr_pend_r) begin
			wr_pend_r <= 1'b0;
		end else if (wr_take) begin
			wr_pend_r <= 1'b1;
			wr_idx_r <= a_idx;
		end
		if (rd_take) begin
			hrdata_r <= {16'h0000, rd_val};
		end
	end
end

// ----------------------------------------
// straps and software registers
// ----------------------------------------
always @* begin
	strap_adv = 4'b1111; // [RL11]
	if (negotiate_strap_enable) begin
		case ({neg_select_hi, neg_select_lo}) // [RL2]
			2'b00: begin
				strap_adv = 4'b0011;
			end
			2'b01: begin
				strap_adv = 4'b1100;
			end
			2'b10: begin
				strap_adv = 4'b0101;
			end
			default: begin
				strap_adv = 4'b1111;
			end
		endcase
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		strap_done_r <= 1'b0;
		armed_r <= 1'b1;
		ctrl_speed_r <= 1'b0;
		ctrl_an_r <= 1'b1;
		ctrl_duplex_r <= 1'b0;
		adv_r <= `ANC_ADV_RESET;
		xcr_r <= `ANC_XCR_RESET;
	end else if (hclk_en) begin
		if (!strap_done_r) begin
			// one capture after release; pins are not looked at again [RL23]
			strap_done_r <= 1'b1;
			armed_r <= negotiate_strap_enable;
			ctrl_an_r <= negotiate_strap_enable;
			ctrl_speed_r <= neg_select_hi; // [RL1]
			ctrl_duplex_r <= neg_select_lo;
			adv_r <= {7'h00, strap_adv, `ANC_SELECTOR}; // [RL3]
			xcr_r[`ANC_XCR_AUTO] <= crossover_strap_enable; // [RL21]
		end else if (wr_pend_r) begin
			case (wr_idx_r)
				`ANC_IDX_CTRL: begin
					ctrl_speed_r <= wd[`ANC_CTRL_SPEED]; // [RL4]
					ctrl_an_r <= wd[`ANC_CTRL_NEGOTIATE_STRAP_ENABLE];
					ctrl_duplex_r <= wd[`ANC_CTRL_DUPLEX];
					if (!wd[`ANC_CTRL_NEGOTIATE_STRAP_ENABLE]) begin
						armed_r <= 1'b1; // [RL20]
					end
				end
				`ANC_IDX_ADV: begin
					adv_r <= wd; // [RL11]
				end
				`ANC_IDX_XCR: begin
					xcr_r <= wd;
				end
				default: begin
					xcr_r <= xcr_r;
				end
			endcase
		end
	end
end

// ----------------------------------------
// negotiation sequencer
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		state_r <= ST_OFF;
		break_cnt_r <= 28'h0000000;
		lpa_r <= 16'h0000;
		pd_fault_r <= 1'b0;
		page_rcvd_r <= 1'b0;
		lp_able_r <= 1'b0;
		res_100_r <= 1'b0;
		res_fd_r <= 1'b0;
	end else if (hclk_en) begin
		// clear on read; a new event in the same cycle keeps its flag
		if (exp_read) begin
			pd_fault_r <= 1'b0;
			page_rcvd_r <= 1'b0;
		end
		if (!an_on) begin
			state_r <= ST_OFF; // [RL7]
		end else if (restart_req) begin
			state_r <= ST_BREAK; // [RL17]
			break_cnt_r <= 28'h0000000;
		end else begin
			case (state_r)
				ST_OFF: begin
					state_r <= ST_BREAK; // [RL19]
					break_cnt_r <= 28'h0000000;
				end
				ST_BREAK: begin
					lp_able_r <= 1'b0;
					if (break_cnt_r == BREAK_LAST) begin
						state_r <= ST_ABIL; // [RL19]
					end else begin
						break_cnt_r <= break_cnt_r + 28'h0000001;
					end
				end
				ST_ABIL: begin
					if (rx_page_valid) begin
						lpa_r <= rx_page; // [RL12]
						page_rcvd_r <= 1'b1;
						lp_able_r <= 1'b1;
					end else if (lp_able_r && res[2]) begin
						state_r <= ST_DONE;
						res_100_r <= res[1];
						res_fd_r <= res[0];
					end else if (!lp_able_r && pd_one) begin
						state_r <= ST_DONE; // [RL15]
						res_100_r <= link_100_good;
						res_fd_r <= 1'b0;
						lpa_r <= link_100_good ? `ANC_PD_100_WORD : `ANC_PD_10_WORD; // [RL13]
					end else if (!lp_able_r && link_10_good && link_100_good) begin
						pd_fault_r <= 1'b1; // [RL16]
					end
				end
				ST_DONE: begin
					if (!sel_link) begin
						state_r <= ST_BREAK; // [RL18]
						break_cnt_r <= 28'h0000000;
					end
				end
				default: begin
					state_r <= ST_OFF;
				end
			endcase
		end
	end
end

// ----------------------------------------
// operating mode and link
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		op_100_r <= 1'b0;
		op_fd_r <= 1'b0;
		link_r <= 1'b0;
	end else if (hclk_en) begin
		op_100_r <= an_on ? res_100_r : ctrl_speed_r; // [RL7]
		op_fd_r <= an_on ? res_fd_r : ctrl_duplex_r;
		link_r <= (!an_on || state_r == ST_DONE) && sel_link; // [RL8]
	end
end

// ----------------------------------------
// crossover
// ----------------------------------------
// the random seed keeps two auto ends from swapping in lockstep forever
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		lfsr_r <= 16'hace1;
		swap_cnt_r <= 16'h0000;
		xover_r <= 1'b0;
		mdi_r <= 1'b0;
	end else if (hclk_en) begin
		lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		if (xcr_r[`ANC_XCR_AUTO] && an_on && state_r == ST_ABIL && !lp_able_r) begin
			if (swap_cnt_r == SWAP_LAST) begin
				swap_cnt_r <= 16'h0000;
				xover_r <= xover_r ^ lfsr_r[0]; // [RL21]
			end else begin
				swap_cnt_r <= swap_cnt_r + 16'h0001;
			end
		end else begin
			swap_cnt_r <= 16'h0000;
		end
		mdi_r <= xcr_r[`ANC_XCR_FORCE] | (xcr_r[`ANC_XCR_AUTO] & an_on & xover_r); // [RL22]
	end
end

// ----------------------------------------
// link side outputs
// ----------------------------------------
assign flp_send = an_on & (state_r == ST_ABIL); // [RL5]
assign tx_page = adv_r; // [RL5]
assign tx_halt = an_on & (state_r == ST_BREAK); // [RL19]
assign speed_100 = op_100_r;
assign full_duplex = op_fd_r;
assign link_up = link_r;
assign mdi_crossover = mdi_r;

endmodule // anc_autoneg_ctrl

// ==== verification/anc_autoneg_assertions.sv ====
/*
 checker for the negotiation control ports.
 assumes a bind onto anc_autoneg_ctrl and one clock domain.
*/
`timescale 1ns/10ps
module anc_autoneg_assertions #(
	parameter BREAK_CYCLES = 20
) (
	input wire hclk,
	input wire hresetn,
	input wire hclk_en,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire link_10_good,
	input wire link_100_good,
	input wire rx_page_valid,
	input wire flp_send,
	input wire tx_halt,
	input wire speed_100,
	input wire link_up
);
	// --------
	// break length counter
	// --------
	logic [31:0] halt_r;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			halt_r <= 32'h0;
		else if (hclk_en)
			halt_r <= tx_halt ? halt_r + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_halt_no_burst: assert property (tx_halt |-> !flp_send)
		else $error("burst during break");
	a_halt_no_link: assert property (tx_halt |=> !link_up)
		else $error("link up during break");
	a_halt_max: assert property (halt_r <= BREAK_CYCLES + 1)
		else $error("break too long");
	a_halt_min: assert property ($fell(tx_halt) |-> halt_r >= BREAK_CYCLES - 1)
		else $error("break too short");
	a_break_burst: assert property ($fell(tx_halt) |-> flp_send)
		else $error("no burst after break");
	a_link_cause: assert property ($rose(link_up) |-> $past(link_10_good || link_100_good))
		else $error("link up without good link");
	a_single_speed: assert property ($rose(link_up) && $past(link_10_good != link_100_good)
		|-> speed_100 == $past(link_100_good))
		else $error("speed differs from the good link");
	a_stall_short: assert property (hclk_en && !hreadyout |=> hreadyout || !hclk_en)
		else $error("stall longer than one cycle");
	a_freeze_wait: assert property (!hclk_en |-> !hreadyout)
		else $error("ready while frozen");
	a_resp_okay: assert property (!hresp && hrdata[31:16] == 16'h0)
		else $error("bad response or upper data");
	c_break: cover property ($fell(tx_halt));
	c_link: cover property ($rose(link_up));
	c_page: cover property (flp_send && rx_page_valid);
endmodule // anc_autoneg_assertions

bind anc_autoneg_ctrl anc_autoneg_assertions #(.BREAK_CYCLES(BREAK_CYCLES)) u_chk (.hclk, .hresetn, .hclk_en,
	.hreadyout, .hresp, .hrdata, .link_10_good, .link_100_good, .rx_page_valid, .flp_send, .tx_halt,
	.speed_100, .link_up);

// ==== verification/anc_link_partner.sv ====
/*
 remote partner: answers a burst with one base page after a delay.
 assumes the bench drives the receiver link levels itself.
*/
`timescale 1ns/10ps
module anc_link_partner (
	input wire hclk,
	input wire flp_send,
	input wire send_page,
	input wire [15:0] page_word,
	input wire [3:0] delay,
	output logic rx_page_valid,
	output logic [15:0] rx_page
);
	logic [3:0] wait_r = 4'h0;
	initial begin
		rx_page_valid = 1'b0;
		rx_page = 16'h0;
	end
	// the word toggles between pages so a stale capture cannot match
	always @(posedge hclk) begin
		rx_page_valid <= 1'b0;
		rx_page <= ~rx_page;
		if (!flp_send || !send_page)
			wait_r <= 4'h0;
		else if (wait_r != 4'hf) begin
			wait_r <= wait_r + 4'h1;
			if (wait_r == delay) begin
				rx_page_valid <= 1'b1;
				rx_page <= page_word;
			end
		end
	end
endmodule // anc_link_partner

// ==== verification/anc_autoneg_ctrl_bench.sv ====
/*
 self-checking bench of the negotiation control block.
 assumes the bench is the only bus master and drives the link levels.
*/
`timescale 1ns/10ps
module anc_autoneg_ctrl_bench;
	logic hclk = 0, hresetn = 0, hclk_en = 1, hsel = 0, hwrite = 0, send_page = 0;
	logic negotiate_strap_enable = 0, neg_select_hi = 0, neg_select_lo = 0;
	logic crossover_strap_enable = 0, link_10_good = 0, link_100_good = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0] htrans = 0, r;
	logic [2:0] hsize = 3'h2;
	logic [3:0] dly = 0;
	logic [15:0] page_word = 0, q, adv;
	wire hreadyout, hresp, rx_page_valid, flp_send, tx_halt, speed_100, full_duplex, link_up, mdi_crossover;
	wire [31:0] hrdata;
	wire [15:0] rx_page, tx_page;
	int failures = 0, total_checks = 0, cyc = 0, i;
	always #5 hclk = ~hclk;
	anc_autoneg_ctrl #(.BREAK_CYCLES(20), .SWAP_CYCLES(8)) i_dut (.hclk, .hresetn, .hclk_en, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.negotiate_strap_enable, .neg_select_hi, .neg_select_lo, .crossover_strap_enable, .link_10_good,
		.link_100_good, .rx_page_valid, .rx_page, .flp_send, .tx_page, .tx_halt, .speed_100, .full_duplex,
		.link_up, .mdi_crossover);
	anc_link_partner u_lp (.hclk, .flp_send, .send_page, .page_word, .delay(dly), .rx_page_valid, .rx_page);
	// --------
	// tasks and expectations
	// --------
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] ix, input logic [15:0] d);
		logic rdy;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {25'h0, ix, 2'b00};
		// ready and data are taken mid-cycle, where they hold the value the edge will see
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			@(posedge hclk);
		end while (rdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {16'h0, d};
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			q = hrdata[15:0];
			@(posedge hclk);
		end while (rdy !== 1'b1);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [4:0] ix, input logic [15:0] exp);
		bus(1'b0, ix, 16'h0);
		chk(q, exp);
	endtask
	task automatic rst();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
	endtask
	function automatic logic [15:0] exp_adv(input logic [2:0] s);
		logic [3:0] a;
		a = !s[2] ? 4'hf : s[1] ? (s[0] ? 4'hf : 4'h5) : (s[0] ? 4'hc : 4'h3);
		return {7'h0, a, 5'h01};
	endfunction
	function automatic logic [1:0] best(input logic [3:0] c);
		return c[3] ? 2'b11 : c[2] ? 2'b10 : c[1] ? 2'b01 : 2'b00;
	endfunction
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 30000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(50));
		for (int s = 0; s < 8; s++) begin
			{negotiate_strap_enable, neg_select_hi, neg_select_lo} <= s[2:0];
			crossover_strap_enable <= 1'($urandom);
			rst();
			{negotiate_strap_enable, neg_select_hi, neg_select_lo} <= 3'($urandom);
			rd(5'h04, exp_adv(s[2:0]));
			rd(5'h01, 16'h7849);
			rd(5'h00, {2'b0, s[1], s[2], 3'h0, s[0], 8'h0});
			rd(5'h19, {crossover_strap_enable, 15'h0});
			if (!s[2])
				chk({speed_100, full_duplex}, s[1:0]);
		end
		rd(5'h02, 16'h0);
		$display("strap test done");
		{negotiate_strap_enable, neg_select_hi, neg_select_lo} <= 3'h7;
		rst();
		do @(posedge hclk); while (flp_send !== 1'b1);
		for (i = 0; i < 4; i++) begin
			adv = {7'h0, 4'($urandom) | 4'h1, 5'h01};
			page_word <= (16'($urandom) & 16'hffe0) | 16'h0021;
			bus(1'b1, 5'h04, adv);
			send_page <= 1'b1;
			dly <= 4'($urandom % 15);
			bus(1'b1, 5'h00, 16'h1200);
			link_10_good <= 1'b0;
			link_100_good <= 1'b0;
			@(posedge hclk);
			#1 chk(tx_halt, 1'b1);
			do @(posedge hclk); while (flp_send !== 1'b1);
			chk(tx_page, adv);
			do @(posedge hclk); while (rx_page_valid !== 1'b1);
			r = best(adv[8:5] & page_word[8:5]);
			link_100_good <= r[1];
			link_10_good <= !r[1];
			do @(posedge hclk); while (link_up !== 1'b1);
			chk({speed_100, full_duplex}, r);
			rd(5'h05, page_word);
			rd(5'h01, 16'h786d | {11'h0, page_word[13], 4'h0});
			rd(5'h10, {11'h0, 1'b1, 1'b0, r[0], !r[1], 1'b1});
			rd(5'h06, {12'h0, page_word[15], 3'h3});
		end
		$display("negotiation test done");
		send_page <= 1'b0;
		for (i = 1; i >= 0; i--) begin
			link_10_good <= 1'b0;
			link_100_good <= 1'b0;
			do @(posedge hclk); while (tx_halt !== 1'b1);
			do @(posedge hclk); while (flp_send !== 1'b1);
			link_10_good <= 1'b1;
			link_100_good <= 1'b1;
			repeat (4) @(posedge hclk);
			bus(1'b0, 5'h06, 16'h0);
			chk(q[4], 1'b1);
			link_10_good <= !i[0];
			link_100_good <= i[0];
			do @(posedge hclk); while (link_up !== 1'b1);
			chk({speed_100, full_duplex}, {i[0], 1'b0});
			rd(5'h05, i[0] ? 16'h0081 : 16'h0021);
			bus(1'b0, 5'h06, 16'h0);
			chk(q[0], 1'b0);
		end
		$display("parallel detect test done");
		{negotiate_strap_enable, crossover_strap_enable} <= 2'b01;
		link_10_good <= 1'b0;
		rst();
		bus(1'b1, 5'h00, 16'h1000);
		hclk_en <= 1'b0;
		repeat (3) @(posedge hclk);
		hclk_en <= 1'b1;
		repeat (40) @(posedge hclk);
		chk({flp_send, tx_halt, mdi_crossover}, 3'h0);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, 5'h00, {2'b0, i[1], 4'h0, i[0], 8'h0});
			repeat (2) @(posedge hclk);
			chk({speed_100, full_duplex}, i[1:0]);
		end
		bus(1'b1, 5'h19, 16'h4000);
		repeat (2) @(posedge hclk);
		chk(mdi_crossover, 1'b1);
		bus(1'b1, 5'h00, 16'h1000);
		do @(posedge hclk); while (flp_send !== 1'b1);
		bus(1'b1, 5'h00, 16'h3100);
		link_10_good <= 1'b1;
		do @(posedge hclk); while (link_up !== 1'b1);
		chk({speed_100, full_duplex}, 2'b00);
		$display("forced mode test done");
		end_of_test();
	end
endmodule // anc_autoneg_ctrl_bench
